// ---- core/hw_event_regs.sv ----
/*
 * Hardware event register bank of the system trace unit with its event
 * capture, pending tracking, lost-event detection and trigger output.
 * Assumes an Avalon-MM master with waitrequest, byte addresses, one clock.
 */
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module hw_event_regs
	import hw_event_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// global trace enable
	input wire logic trace_enable,
	// hardware event inputs
	input wire logic [MAX_EVENTS-1:0] hw_event,
	// pending event drain
	output logic evt_valid,
	output logic [IDX_W-1:0] evt_index,
	input wire logic evt_ready,
	// side outputs
	output logic evt_lost,
	output logic trig_out,
	output logic comp_active,
	output logic [31:0] ext_mux_select_field,
	output logic [15:0] master_number
);
	feature_if feat ();

	hw_event_features u_features (
		.feat(feat)
	);

	logic ack_q;
	logic req;
	logic wr_go;
	logic [31:0] readdata_q;
	logic [2:0] main_ctrl_q;
	logic [31:0] master_q;
	logic [BANK_W-1:0] trig_en_q [NUM_BANKS];
	logic [BSEL_W-1:0] bank_sel_q;
	logic [31:0] ext_mux_q;
	logic lost_q;
	logic [MAX_EVENTS-1:0] evt_prev_q;
	logic [MAX_EVENTS-1:0] pend_q;
	logic [MAX_EVENTS-1:0] pend_d;
	logic [MAX_EVENTS-1:0] rise;
	logic [MAX_EVENTS-1:0] clr;
	logic [MAX_EVENTS-1:0] collide;
	logic [MAX_EVENTS-1:0] ev_mask;
	logic [MAX_EVENTS-1:0] trig_flat;
	logic [IDX_W-1:0] first_d;
	logic valid_q;
	logic [IDX_W-1:0] index_q;
	logic lost_pulse_q;
	logic trig_q;
	logic tracing;
	logic err_on;
	logic take;
	logic [BSEL_W-1:0] bank;
	logic [31:0] rd_d;
	logic stat_clr;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// bus handshake: one wait cycle per access
	assign req = read | write;
	assign waitrequest = req & ~ack_q;
	assign wr_go = write & ack_q;
	assign readdata = readdata_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// bank used for trigger enable and pending window
	assign bank = feat.bank_present ? bank_sel_q : '0;

	always_comb begin
		rd_d = ZERO_WORD;
		case (address)
			OFS_FEATURE: rd_d = feat.word;
			OFS_MAIN_CTRL: rd_d = {29'h0000_0000, main_ctrl_q};
			OFS_MASTER: rd_d = master_q & MASTER_MASK;
			OFS_TRIG_EN: rd_d = feat.trig_cap ? trig_en_q[bank] : ZERO_WORD;
			OFS_BANK_SEL: rd_d = feat.bank_present ? {29'h0000_0000, bank_sel_q} : ZERO_WORD;
			OFS_EXT_MUX: rd_d = ext_mux_q & feat.mux_mask;
			OFS_STATUS: begin
				rd_d[STAT_LOST] = lost_q;
				rd_d[STAT_PEND] = |pend_q;
			end
			OFS_PENDING: rd_d = pend_q[bank*BANK_W +: BANK_W];
			default: rd_d = ZERO_WORD;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata_q <= ZERO_WORD;
		end else if (read & ~ack_q) begin
			readdata_q <= rd_d;
		end
	end

	// main control; unsupported bits stay zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			main_ctrl_q <= MCR_RESET;
		end else if (wr_go && address == OFS_MAIN_CTRL && byteenable[0]) begin
			main_ctrl_q[MCR_EN] <= writedata[MCR_EN];
			main_ctrl_q[MCR_COMPRESSION_ENABLE] <= writedata[MCR_COMPRESSION_ENABLE] & (feat.comp_cap == COMP_PROG);
			main_ctrl_q[MCR_ERRDET] <= writedata[MCR_ERRDET] & feat.err_cap;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			master_q <= CFG_MASTER_RESET;
		end else if (wr_go && address == OFS_MASTER && feat.master_rw) begin
			master_q <= merge(master_q, writedata, byteenable) & MASTER_MASK;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_sel_q <= '0;
		end else if (wr_go && address == OFS_BANK_SEL && feat.bank_present && byteenable[0]) begin
			bank_sel_q <= writedata[BSEL_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_mux_q <= ZERO_WORD;
		end else if (wr_go && address == OFS_EXT_MUX && feat.mux_present) begin
			ext_mux_q <= merge(ext_mux_q, writedata, byteenable) & feat.mux_mask;
		end
	end

	// per-bank trigger enables, inputs beyond the supported count forced off
	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++) begin : gen_bank
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					trig_en_q[g] <= '0;
				end else if (wr_go && address == OFS_TRIG_EN && feat.trig_cap && bank == BSEL_W'(g)) begin
					trig_en_q[g] <= merge(trig_en_q[g], writedata, byteenable)
						& ev_mask[g*BANK_W +: BANK_W];
				end
			end
			assign trig_flat[g*BANK_W +: BANK_W] = trig_en_q[g];
		end
	endgenerate

	assign tracing = main_ctrl_q[MCR_EN] & trace_enable;
	assign err_on = main_ctrl_q[MCR_ERRDET] & feat.err_cap;
	assign take = valid_q & evt_ready;
	assign stat_clr = wr_go && address == OFS_STATUS && byteenable[0] && writedata[STAT_LOST];

	// per-event capture: rising edge sets pending, a repeat while pending is lost
	generate
		for (g = 0; g < MAX_EVENTS; g++) begin : gen_evt
			assign ev_mask[g] = (g < CFG_NUM_EVENTS);
			assign rise[g] = tracing & ev_mask[g] & hw_event[g] & ~evt_prev_q[g];
			assign clr[g] = take && index_q == IDX_W'(g);
			assign collide[g] = rise[g] & pend_q[g] & ~clr[g];
			assign pend_d[g] = (pend_q[g] & ~clr[g]) | rise[g];
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_prev_q <= '0;
			pend_q <= '0;
		end else begin
			evt_prev_q <= hw_event;
			pend_q <= tracing ? pend_d : '0;
		end
	end

	// lowest pending event goes out first
	always_comb begin
		first_d = '0;
		for (int i = MAX_EVENTS - 1; i >= 0; i--) begin
			if (pend_d[i]) begin
				first_d = IDX_W'(i);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= 1'b0;
			index_q <= '0;
		end else begin
			valid_q <= tracing & (|pend_d);
			index_q <= first_d;
		end
	end

	// sticky lost flag, a new loss beats a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lost_q <= 1'b0;
			lost_pulse_q <= 1'b0;
		end else begin
			lost_pulse_q <= err_on & (|collide);
			if (err_on & (|collide)) begin
				lost_q <= 1'b1;
			end else if (stat_clr) begin
				lost_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= feat.trig_cap & (|(rise & trig_flat));
		end
	end

	assign evt_valid = valid_q;
	assign evt_index = index_q;
	assign evt_lost = lost_pulse_q;
	assign trig_out = trig_q;
	assign comp_active = (feat.comp_cap == COMP_ALWAYS) | main_ctrl_q[MCR_COMPRESSION_ENABLE];
	assign ext_mux_select_field = ext_mux_q;
	assign master_number = master_q[15:0];
endmodule : hw_event_regs

// ---- core/hw_event_pkg.sv ----
/*
 * Constants for the hardware event block of the system trace unit:
 * configuration, register offsets, field positions and reset values.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package hw_event_pkg;
	// implementation configuration
	localparam logic [2:0] CFG_MUX_CODE = 3'h3;
	localparam int CFG_NUM_EVENTS = 64;
	localparam logic [1:0] CFG_COMP_CAP = 2'h3;
	localparam logic CFG_MASTER_RW = 1'b1;
	localparam logic CFG_ERR_CAP = 1'b1;
	localparam logic CFG_TRIG_CAP = 1'b1;
	localparam logic [31:0] CFG_MASTER_RESET = 32'h0000_0000;

	localparam int MAX_EVENTS = 256;
	localparam int BANK_W = 32;
	localparam int NUM_BANKS = MAX_EVENTS / BANK_W;
	localparam int BSEL_W = 3;
	localparam int IDX_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [8:0] BANK_LIMIT = 9'h020;

	// field positions in the feature word
	localparam int MUX_LSB = 28;
	localparam int NUMEV_LSB = 15;
	localparam int COMP_LSB = 4;
	localparam int MASTER_BIT = 3;
	localparam int ERR_BIT = 2;
	localparam int TRIG_BIT = 0;
	localparam logic [2:0] MUX_CODE_MAX = 3'h5;
	localparam logic [3:0] CLASS_REV_V1 = 4'h0;
	localparam logic [3:0] CFG_CLASS_REV = 4'h1;

	// compression capability codes
	localparam logic [1:0] COMP_ALWAYS = 2'h2;
	localparam logic [1:0] COMP_PROG = 2'h3;

	// main control bits
	localparam int MCR_EN = 0;
	localparam int MCR_COMPRESSION_ENABLE = 1;
	localparam int MCR_ERRDET = 2;
	localparam logic [2:0] MCR_RESET = 3'h0;

	// status bits
	localparam int STAT_LOST = 0;
	localparam int STAT_PEND = 1;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_FEATURE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MAIN_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MASTER = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_TRIG_EN = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_BANK_SEL = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EXT_MUX = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h1C;

	localparam logic [31:0] MASTER_MASK = 32'h0000_FFFF;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : hw_event_pkg

// ---- core/feature_if.sv ----
/*
 * Carrier for the fixed feature word and the capability flags decoded
 * from it. Assumes one producer and one consumer.
 */
`timescale 1ns/1ps
interface feature_if;
	logic [31:0] word;
	logic [31:0] mux_mask;
	logic mux_present;
	logic [1:0] comp_cap;
	logic master_rw;
	logic err_cap;
	logic trig_cap;
	logic bank_present;
	logic [8:0] num_events;

	modport src (output word, mux_mask, mux_present, comp_cap, master_rw, err_cap, trig_cap, bank_present,
		num_events);
	modport dst (input word, mux_mask, mux_present, comp_cap, master_rw, err_cap, trig_cap, bank_present,
		num_events);
endinterface : feature_if

// ---- core/hw_event_features.sv ----
/*
 * Builds the constant feature word from the package configuration.
 * Assumes nothing of its surroundings; all outputs are constants.
 */
`timescale 1ns/1ps
module hw_event_features
	import hw_event_pkg::*;
(
	// feature word out
	feature_if.src feat
);
	logic [2:0] mux_code;
	logic [8:0] num_ev;
	logic [5:0] mux_bits;

	always_comb begin
		mux_code = CFG_MUX_CODE;
		if (CFG_CLASS_REV == CLASS_REV_V1 || CFG_MUX_CODE > MUX_CODE_MAX) begin
			mux_code = 3'h0;
		end
	end

	// 2, 4, 8, 16 or 32 select bits for codes one to five
	assign mux_bits = (mux_code == 3'h0) ? 6'h00 : 6'(6'h01 << mux_code);
	assign feat.mux_mask = (mux_bits == 6'h20) ? 32'hFFFF_FFFF : 32'((33'h1 << mux_bits) - 33'h1);
	assign feat.mux_present = (mux_code != 3'h0);
	assign num_ev = 9'(CFG_NUM_EVENTS);
	assign feat.num_events = num_ev;
	assign feat.comp_cap = CFG_COMP_CAP;
	assign feat.master_rw = CFG_MASTER_RW;
	assign feat.err_cap = CFG_ERR_CAP;
	assign feat.trig_cap = CFG_TRIG_CAP;
	assign feat.bank_present = (num_ev > BANK_LIMIT);

	always_comb begin
		feat.word = ZERO_WORD;
		feat.word[MUX_LSB +: 3] = mux_code;
		feat.word[NUMEV_LSB +: 9] = num_ev;
		feat.word[COMP_LSB +: 2] = CFG_COMP_CAP;
		feat.word[MASTER_BIT] = CFG_MASTER_RW;
		feat.word[ERR_BIT] = CFG_ERR_CAP;
		feat.word[TRIG_BIT] = CFG_TRIG_CAP;
	end
endmodule : hw_event_features

// ---- bench/hw_event_regs_chk.sv ----
/*
 * Checker for the hw_event_regs ports: bus handshake, feature word, masks.
 * Assumes it is bound to hw_event_regs and that there is a single clock.
 */
`timescale 1ns/1ps
module hw_event_regs_chk
	import hw_event_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register bus
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// side outputs
	input wire logic evt_valid,
	input wire logic evt_lost,
	input wire logic [31:0] ext_mux_select_field,
	input wire logic [15:0] master_number
);
	localparam logic [2:0] MUX_EXP = (CFG_CLASS_REV == CLASS_REV_V1) ? 3'h0 : CFG_MUX_CODE;
	localparam logic [31:0] FEAT_EXP = {1'h0, MUX_EXP, 4'h0, 9'(CFG_NUM_EVENTS), 9'h000, CFG_COMP_CAP,
		CFG_MASTER_RW, CFG_ERR_CAP, 1'h0, CFG_TRIG_CAP};
	localparam int MUX_W = 1 << MUX_EXP;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_req_wait;
		(read || write) && waitrequest;
	endsequence
	sequence s_rd_ack;
		read && !waitrequest;
	endsequence

	a_wait_first: assert property (
		(read || write) && !$past(read || write) |-> waitrequest) else $error("request without wait cycle");
	a_one_wait: assert property (
		s_req_wait |=> !waitrequest) else $error("more than one wait cycle");
	a_idle_ready: assert property (
		!(read || write) |-> !waitrequest) else $error("waitrequest high while idle");
	a_feature_word: assert property (
		(s_rd_ack ##0 address == OFS_FEATURE) |-> readdata == FEAT_EXP) else $error("feature word wrong");
	a_mux_width: assert property (
		(ext_mux_select_field >> MUX_W) == '0) else $error("mux select wider than reported");
	a_master_read: assert property (
		(s_rd_ack ##0 address == OFS_MASTER) |-> readdata == {16'h0000, master_number})
		else $error("master number read mismatch");
	a_bank_width: assert property (
		(s_rd_ack ##0 address == OFS_BANK_SEL) |-> readdata[31:BSEL_W] == '0) else $error("bank select too wide");
	a_lost_pending: assert property (
		evt_lost |-> $past(evt_valid)) else $error("lost flag without pending event");
endmodule : hw_event_regs_chk

bind hw_event_regs hw_event_regs_chk chk_u (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
	.write(write), .readdata(readdata), .waitrequest(waitrequest), .evt_valid(evt_valid), .evt_lost(evt_lost),
	.ext_mux_select_field(ext_mux_select_field), .master_number(master_number));

// ---- bench/hw_event_feature_id_register_bench.sv ----
/*
 * Self-checking bench for hw_event_regs: register reads and writes over
 * Avalon-MM, one event walk. Assumes the package configuration as shipped.
 */
`timescale 1ns/1ps
module hw_event_feature_id_register_bench;
	import hw_event_pkg::*;
	localparam logic [31:0] FEAT = {1'h0, (CFG_CLASS_REV == CLASS_REV_V1) ? 3'h0 : CFG_MUX_CODE, 4'h0,
		9'(CFG_NUM_EVENTS), 9'h000, CFG_COMP_CAP, CFG_MASTER_RW, CFG_ERR_CAP, 1'h0, CFG_TRIG_CAP};
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] address = 8'h00;
	logic read = 1'h0;
	logic write = 1'h0;
	logic [3:0] byteenable = 4'hF;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic waitrequest;
	logic trace_enable = 1'h1;
	logic [MAX_EVENTS-1:0] hw_event = '0;
	logic evt_valid;
	logic [7:0] evt_index;
	logic evt_ready = 1'h0;
	logic evt_lost;
	logic trig_out;
	logic comp_active;
	logic [31:0] ext_mux_select_field;
	logic [15:0] master_number;
	int bad_count = 0;
	int tests_run = 0;
	logic [31:0] q;

	hw_event_regs dut_u (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.trace_enable(trace_enable), .hw_event(hw_event), .evt_valid(evt_valid), .evt_index(evt_index),
		.evt_ready(evt_ready), .evt_lost(evt_lost), .trig_out(trig_out), .comp_active(comp_active),
		.ext_mux_select_field(ext_mux_select_field), .master_number(master_number));

	initial begin
		forever #2.5 clk = ~clk;
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		// hold until waitrequest is seen low; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'h0);
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
	endtask : bus

	task rd(input logic [7:0] a, input string name, input logic [31:0] exp);
		bus(1'h0, a, 32'h0000_0000);
		check(name, q, exp);
	endtask : rd

	task tick;
		@(posedge clk);
		#1;
	endtask : tick

	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (4000) @(posedge clk);
		bad_count++;
		wrap_up();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		rd(OFS_FEATURE, "feature", FEAT);
		bus(1'h1, OFS_FEATURE, 32'hFFFF_FFFF);
		rd(OFS_FEATURE, "feature after write", FEAT);
		rd(8'h3C, "unmapped", 32'h0000_0000);
		$display("feature word test done");
		bus(1'h1, OFS_MASTER, 32'h1234_ABCD);
		rd(OFS_MASTER, "master", 32'h0000_ABCD);
		check("master port", {16'h0000, master_number}, 32'h0000_ABCD);
		byteenable <= 4'h2;
		bus(1'h1, OFS_MASTER, 32'h0000_5500);
		byteenable <= 4'hF;
		rd(OFS_MASTER, "master one lane", 32'h0000_55CD);
		bus(1'h1, OFS_EXT_MUX, 32'hFFFF_FFFF);
		rd(OFS_EXT_MUX, "ext mux", 32'h0000_00FF);
		bus(1'h1, OFS_BANK_SEL, 32'h0000_0001);
		rd(OFS_BANK_SEL, "bank select", 32'h0000_0001);
		bus(1'h1, OFS_BANK_SEL, 32'h0000_0000);
		$display("writable register test done");
		bus(1'h1, OFS_MAIN_CTRL, 32'h0000_0005);
		bus(1'h1, OFS_TRIG_EN, 32'h0000_0020);
		rd(OFS_TRIG_EN, "trigger enable", 32'h0000_0020);
		@(posedge clk);
		hw_event[5] <= 1'h1;
		@(posedge clk);
		hw_event[5] <= 1'h0;
		#1;
		check("valid", {31'h0, evt_valid}, 32'h0000_0001);
		check("index", {24'h00_0000, evt_index}, 32'h0000_0005);
		check("trigger", {31'h0, trig_out}, 32'h0000_0001);
		@(posedge clk);
		hw_event[5] <= 1'h1;
		tick();
		check("lost", {31'h0, evt_lost}, 32'h0000_0001);
		rd(OFS_STATUS, "status", 32'h0000_0003);
		rd(OFS_PENDING, "pending window", 32'h0000_0020);
		@(posedge clk);
		evt_ready <= 1'h1;
		hw_event[5] <= 1'h0;
		@(posedge clk);
		evt_ready <= 1'h0;
		#1;
		check("drained", {31'h0, evt_valid}, 32'h0000_0000);
		bus(1'h1, OFS_STATUS, 32'h0000_0001);
		rd(OFS_STATUS, "status cleared", 32'h0000_0000);
		$display("event test done");
		bus(1'h1, OFS_MAIN_CTRL, 32'h0000_0003);
		rd(OFS_MAIN_CTRL, "main control", 32'h0000_0003);
		check("compression", {31'h0, comp_active}, 32'h0000_0001);
		$display("compression test done");
		// repeat with error detect off: no loss reported, no trigger on bit 6
		@(posedge clk);
		hw_event[6] <= 1'h1;
		@(posedge clk);
		hw_event[6] <= 1'h0;
		@(posedge clk);
		hw_event[6] <= 1'h1;
		tick();
		check("no lost without detect", {31'h0, evt_lost}, 32'h0000_0000);
		check("no trigger when disabled", {31'h0, trig_out}, 32'h0000_0000);
		rd(OFS_STATUS, "status without detect", 32'h0000_0002);
		trace_enable <= 1'h0;
		hw_event[6] <= 1'h0;
		@(posedge clk);
		#1;
		check("pending dropped", {31'h0, evt_valid}, 32'h0000_0000);
		rd(OFS_STATUS, "status after disable", 32'h0000_0000);
		$display("detect off test done");
		rst_n <= 1'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		rd(OFS_MASTER, "master after reset", CFG_MASTER_RESET & MASTER_MASK);
		rd(OFS_MAIN_CTRL, "main control after reset", {29'h0000_0000, MCR_RESET});
		rd(OFS_FEATURE, "feature after reset", FEAT);
		$display("mid-run reset test done");
		wrap_up();
	end
endmodule : hw_event_feature_id_register_bench
